/* File: hw/reset_cause_pkg.sv */
// Types shared by the reset cause capture block.
// Assumes the constants header is included by the design file.
package reset_cause_pkg;
  typedef enum logic [2:0] {
    ST_RUN,
    ST_SUPPLY_LOW,
    ST_STABILIZE,
    ST_PIN_LOW,
    ST_HOLD_CPU
  } seq_state_t;
endpackage

/* File: hw/reset_cause_regs.svh */
// Offsets, field positions, reset values and timing counts of the reset
// cause capture block. Included by the design; definitions only.
`ifndef RESET_CAUSE_REGS_SVH
`define RESET_CAUSE_REGS_SVH

// Register word addresses on the plain register port
`define WATCHDOG_SERVICE_ADDR 16'hffff
`define RESET_CAUSE_ADDR 16'hfe01
`define CONFIG_ONE_ADDR 16'hfe02
`define IRQ_ENABLE_ADDR 16'hfe03
`define IRQ_CLEAR_ADDR 16'hfe04
`define IRQ_STATUS_ADDR 16'hfe05

// Reset cause register bit positions
`define CAUSE_POWER_ON 7
`define CAUSE_PIN 6
`define CAUSE_WATCHDOG 5
`define CAUSE_ILLEGAL_OPCODE 4
`define CAUSE_ILLEGAL_ADDRESS 3
`define CAUSE_LOW_SUPPLY 1
`define CAUSE_POWER_ON_VALUE 8'h80

// Config register one: stop enable bit, reset value
`define CONFIG_STOP_ENABLE 0
`define CONFIG_ONE_RESET 8'h00

// Timing in oscillator clock cycles
`define STAB_CYCLES 4096
`define PIN_RELEASE_CYCLES 32
`define CPU_RELEASE_CYCLES 64
`define PIN_SAMPLE_CYCLES 32
`define COUNT_W 13

`endif

/* File: hw/reset_source_capture.sv */
// Reset source detection, pin/CPU release sequencing and cause flags.
// Assumes one 100 MHz clock, oscillator enable pulses from a divider, and
// the open-drain reset pin resolved outside this module.
//
// The address-and-strobe port is this design's own decision.
`include "reset_cause_regs.svh"

module reset_source_capture #(
  parameter int WDOG_W = 18,
  parameter int STAB_CYCLES = `STAB_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic osc_en_i,
  input wire logic supply_low_i,
  input wire logic opcode_fetch_i,
  input wire logic opcode_illegal_i,
  input wire logic opcode_stop_i,
  input wire logic addr_unmapped_i,
  input wire logic reset_pin_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [7:0] reg_rdata_o,
  output logic reset_pin_o,
  output logic reset_pin_oe_o,
  output logic clocks_stopped_o,
  output logic cpu_reset_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Strobe aimed at one register word; shared by every strobe decoder below, not the read data case
  function automatic logic reg_hit(
    input logic strobe,
    input logic [15:0] addr,
    input logic [15:0] target
  );
    return strobe && (addr == target);
  endfunction

  // Terminal count of an oscillator-paced counter; the limit is a count,
  // so the last pulse is the one seen while the counter reads limit - 1
  function automatic logic count_done(
    input logic [`COUNT_W-1:0] cnt,
    input logic [`COUNT_W-1:0] limit
  );
    return cnt == (limit - 1'b1);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers: three stages, change taken when 2 and 3 agree

  // Supply level and reset pin come from outside this clock domain. Three
  // stages give the first one a full cycle to settle; requiring stages two
  // and three to agree also rejects a single-cycle glitch on either input.
  // The pin chain resets high, the idle level of the pulled-up pin, so no
  // false low is seen right after reset.
  logic [2:0] supply_sync_q;
  logic [2:0] pin_sync_q;
  logic supply_low_q;
  logic pin_level_q;

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      supply_sync_q <= 3'h0;
      pin_sync_q <= 3'h7;
    end else begin
      supply_sync_q <= {supply_sync_q[1:0], supply_low_i};
      pin_sync_q <= {pin_sync_q[1:0], reset_pin_i};
    end
  end

  // Latency from a pin change to the filtered level is four clocks, far
  // shorter than any count the sequencer makes, so nothing budgets for it.
  // Filtered levels only move when the last two stages agree
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      supply_low_q <= 1'b0;
      pin_level_q <= 1'b1;
    end else begin
      if (supply_sync_q[2] == supply_sync_q[1]) begin
        supply_low_q <= supply_sync_q[2];
      end
      if (pin_sync_q[2] == pin_sync_q[1]) begin
        pin_level_q <= pin_sync_q[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register decode

  logic [7:0] config_q;
  logic wdog_service;
  logic cause_read;

  // Any data value services the watchdog; only the address matters
  assign wdog_service = reg_hit(reg_write_i, reg_addr_i, `WATCHDOG_SERVICE_ADDR);
  // Writes to the cause word fall through every decoder and are lost
  assign cause_read = reg_hit(reg_read_i, reg_addr_i, `RESET_CAUSE_ADDR);

  // Config register one; survives internal resets, set by bus only
  // Only the stop enable bit is used here; the rest of the byte is kept so
  // software reads back what it wrote.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      config_q <= `CONFIG_ONE_RESET;
    end else if (reg_hit(reg_write_i, reg_addr_i, `CONFIG_ONE_ADDR)) begin
      config_q <= reg_wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Internal reset sources

  logic [WDOG_W-1:0] wdog_cnt_q;
  logic wdog_ovf;
  logic illegal_opcode_flag_event;
  logic illegal_address_flag_event;
  logic in_reset;
  logic sequencing;

  assign wdog_ovf = osc_en_i && (&wdog_cnt_q);
  // Triggers are blocked while a sequence runs: the CPU is not fetching
  // then, and a stray qualifier must not extend or restart the hold.
  // Stop is illegal only while stop enable is clear
  assign illegal_opcode_flag_event = opcode_fetch_i && !in_reset && (opcode_illegal_i ||
    (opcode_stop_i && !config_q[`CONFIG_STOP_ENABLE]));
  // Only opcode fetches qualify; data strays to unmapped space are harmless
  assign illegal_address_flag_event = opcode_fetch_i && addr_unmapped_i && !in_reset;

  // The watchdog width sets its timeout: 2**WDOG_W oscillator pulses after
  // the last service. Holding it clear during a sequence means software
  // gets a full period after the CPU is released.
  // Watchdog counts oscillator cycles, held clear while in reset
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wdog_cnt_q <= '0;
    end else if (wdog_service || in_reset) begin
      wdog_cnt_q <= '0;
    end else if (osc_en_i) begin
      wdog_cnt_q <= wdog_cnt_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reset sequencer

  reset_cause_pkg::seq_state_t state_q;
  logic [`COUNT_W-1:0] cnt_q;
  logic pin_sample_pending_q;
  logic [5:0] sample_cnt_q;
  logic internal_trigger;

  assign internal_trigger = wdog_ovf || illegal_opcode_flag_event || illegal_address_flag_event;
  assign in_reset = (state_q != reset_cause_pkg::ST_RUN);
  assign sequencing = in_reset;

  // Timeline of one sequence, in oscillator pulses:
  //   supply low : pin and clocks held until the filtered level clears
  //   stabilise  : STAB_CYCLES pulses, pin low, clocks still stopped
  //   pin low    : 32 pulses, clocks running, pin still pulled
  //   hold cpu   : 32 more pulses with the pin released, CPU still reset
  // Internal sources enter at pin low and skip the first two steps.
  // A supply drop at any point restarts from the top, since the earlier
  // count was made on a supply that could not be trusted.
  // Power-up enters stabilisation like a power-on reset would
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= reset_cause_pkg::ST_STABILIZE;
      cnt_q <= '0;
    end else if (supply_low_q) begin
      state_q <= reset_cause_pkg::ST_SUPPLY_LOW;
      cnt_q <= '0;
    end else begin
      unique case (state_q)
        // Normal running; any internal source starts the short sequence
        reset_cause_pkg::ST_RUN: begin
          if (internal_trigger) begin
            state_q <= reset_cause_pkg::ST_PIN_LOW;
            cnt_q <= '0;
          end
        end
        // Supply has recovered once the priority branch above lets go
        reset_cause_pkg::ST_SUPPLY_LOW: begin
          state_q <= reset_cause_pkg::ST_STABILIZE;
          cnt_q <= '0;
        end
        // Oscillator settling with clocks stopped and the pin pulled
        reset_cause_pkg::ST_STABILIZE: begin
          if (osc_en_i) begin
            if (count_done(cnt_q, `COUNT_W'(STAB_CYCLES))) begin
              state_q <= reset_cause_pkg::ST_PIN_LOW;
              cnt_q <= '0;
            end else begin
              cnt_q <= cnt_q + 1'b1;
            end
          end
        end
        // Pin pulled so that other chips on the line see the reset
        reset_cause_pkg::ST_PIN_LOW: begin
          if (osc_en_i) begin
            if (count_done(cnt_q, `COUNT_W'(`PIN_RELEASE_CYCLES))) begin
              state_q <= reset_cause_pkg::ST_HOLD_CPU;
              cnt_q <= '0;
            end else begin
              cnt_q <= cnt_q + 1'b1;
            end
          end
        end
        // Hold counts the gap between pin release and CPU release, the
        // difference of the two release counts
        reset_cause_pkg::ST_HOLD_CPU: begin
          if (osc_en_i) begin
            if (count_done(cnt_q, `COUNT_W'(`CPU_RELEASE_CYCLES - `PIN_RELEASE_CYCLES))) begin
              state_q <= reset_cause_pkg::ST_RUN;
              cnt_q <= '0;
            end else begin
              cnt_q <= cnt_q + 1'b1;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin, clock and CPU outputs, all registered

  // Outputs are decoded from the state register one cycle late; the
  // internal trigger is ORed in so the pin and CPU respond on the same edge
  // as the state change rather than one later.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      // Reset holds everything: pin pulled, clocks stopped, CPU held
      reset_pin_o <= 1'b0;
      reset_pin_oe_o <= 1'b1;
      clocks_stopped_o <= 1'b1;
      cpu_reset_o <= 1'b1;
    end else begin
      reset_pin_o <= 1'b0; // Open drain: only ever drives low
      reset_pin_oe_o <= (state_q == reset_cause_pkg::ST_SUPPLY_LOW) ||
        (state_q == reset_cause_pkg::ST_STABILIZE) ||
        (state_q == reset_cause_pkg::ST_PIN_LOW) || internal_trigger;
      clocks_stopped_o <= (state_q == reset_cause_pkg::ST_SUPPLY_LOW) ||
        (state_q == reset_cause_pkg::ST_STABILIZE);
      cpu_reset_o <= sequencing || internal_trigger;
    end
  end

  // Pin sample timer: armed at release, looks 32 oscillator cycles later
  // The timer is re-armed for as long as the pin-low step lasts; the wait
  // falls inside the hold step, where triggers are blocked and cannot restart it.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_sample_pending_q <= 1'b0;
      sample_cnt_q <= '0;
    end else if (state_q == reset_cause_pkg::ST_PIN_LOW) begin
      pin_sample_pending_q <= 1'b1;
      sample_cnt_q <= '0;
    end else if (pin_sample_pending_q && osc_en_i) begin
      if (count_done(`COUNT_W'(sample_cnt_q), `COUNT_W'(`PIN_SAMPLE_CYCLES))) begin
        pin_sample_pending_q <= 1'b0;
      end
      sample_cnt_q <= sample_cnt_q + 1'b1;
    end
  end

  logic pin_event;
  assign pin_event = pin_sample_pending_q && osc_en_i && !pin_level_q &&
    count_done(`COUNT_W'(sample_cnt_q), `COUNT_W'(`PIN_SAMPLE_CYCLES));

  ////////////////////////////////////////////////////////////////////////
  // Reset cause register: sticky, cleared only by its own read

  // Bit map: 7 power-on, 6 pin held low by others, 5 watchdog,
  // 4 illegal opcode, 3 illegal address, 1 low supply; 2 and 0 read as 0.
  // The power-on bit is only ever set by the asynchronous reset, so a
  // read after power-up leaves it clear for good.
  logic [7:0] cause_q;
  logic [7:0] cause_set;

  // Low supply keeps setting its flag while the filtered level is low, so a
  // read during a long brown-out still reports it.
  always_comb begin
    cause_set = 8'h00;
    cause_set[`CAUSE_WATCHDOG] = wdog_ovf;
    cause_set[`CAUSE_ILLEGAL_OPCODE] = illegal_opcode_flag_event;
    cause_set[`CAUSE_ILLEGAL_ADDRESS] = illegal_address_flag_event;
    cause_set[`CAUSE_LOW_SUPPLY] = supply_low_q;
    cause_set[`CAUSE_PIN] = pin_event;
  end

  // A read clears the flags on the edge that latches the read data, so the
  // value returned is exactly the set that was cleared.
  // Set beats clear so an event in the read cycle is not lost
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cause_q <= `CAUSE_POWER_ON_VALUE;
    end else if (cause_read) begin
      cause_q <= cause_set;
    end else begin
      cause_q <= cause_q | cause_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt status, enable and write-one clear

  // Status bits follow the cause events but are cleared by writing ones to
  // the clear word, so software can acknowledge the interrupt and leave the
  // cause record untouched. The output is registered and so lags the
  // status by one cycle.
  logic [7:0] irq_status_q;
  logic [7:0] irq_enable_q;
  logic [7:0] irq_clear;

  assign irq_clear = reg_hit(reg_write_i, reg_addr_i, `IRQ_CLEAR_ADDR) ? reg_wdata_i : 8'h00;

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_status_q <= 8'h00;
      irq_enable_q <= 8'h00;
      irq_o <= 1'b0;
    end else begin
      irq_status_q <= (irq_status_q & ~irq_clear) | cause_set;
      // Enable is a plain read/write mask of the status layout
      if (reg_hit(reg_write_i, reg_addr_i, `IRQ_ENABLE_ADDR)) begin
        irq_enable_q <= reg_wdata_i;
      end
      irq_o <= |(irq_status_q & irq_enable_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe; unmapped reads return zero
  // Returning zero outside the read cycle keeps the bus free of stale data
  // and makes a late sample read as zero rather than as an old value.

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_read_i) begin
      unique case (reg_addr_i)
        `RESET_CAUSE_ADDR: reg_rdata_o <= cause_q;
        `CONFIG_ONE_ADDR: reg_rdata_o <= config_q;
        `IRQ_ENABLE_ADDR: reg_rdata_o <= irq_enable_q;
        `IRQ_STATUS_ADDR: reg_rdata_o <= irq_status_q;
        default: reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

endmodule

/* File: sim/reset_pin_partner.sv */
// Other chips on the shared open-drain reset pin.
// Assumes a pull-up; the bench commands when they hold the pin low.
module reset_pin_partner (
  input wire logic drv_i,
  input wire logic oe_i,
  input wire logic hold_low_i,
  output logic pin_o
);
  ////////////////////////////////////////////////////////////////////////////////
  // Wired low wins; the pull-up never leaves the pin floating
  assign pin_o = ((oe_i && !drv_i) || hold_low_i) ? 1'b0 : 1'b1;
endmodule

/* File: sim/reset_source_capture_asserts.sv */
// Port checks for the reset source capture block.
// Assumes the constants header and a bind onto the design top.
`include "reset_cause_regs.svh"
module reset_capture_checker #(parameter int WDOG_W = 18, parameter int STAB_CYCLES = 4096) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic osc_en_i,
  input wire logic supply_low_i,
  input wire logic opcode_fetch_i,
  input wire logic opcode_illegal_i,
  input wire logic opcode_stop_i,
  input wire logic addr_unmapped_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reset_pin_oe_o,
  input wire logic clocks_stopped_o,
  input wire logic cpu_reset_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);
  logic trig;
  logic stop_en_q;
  logic [7:0] pin_cnt_q;
  logic [7:0] cpu_cnt_q;
  ////////////////////////////////////////////////////////////////////////////////
  // Fetches only count while no sequence runs
  assign trig = opcode_fetch_i && !cpu_reset_o && !clocks_stopped_o;
  // Shadow of stop enable
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i)
      stop_en_q <= 1'b0;
    else if (reg_write_i && reg_addr_i == `CONFIG_ONE_ADDR)
      stop_en_q <= reg_wdata_i[`CONFIG_STOP_ENABLE];
  end
  // Oscillator pulses while held, clocks running; stab delay excluded
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_cnt_q <= 8'h00;
      cpu_cnt_q <= 8'h00;
    end else begin
      pin_cnt_q <= reset_pin_oe_o ? pin_cnt_q + 8'(osc_en_i && !clocks_stopped_o) : 8'h00;
      cpu_cnt_q <= cpu_reset_o ? cpu_cnt_q + 8'(osc_en_i && !clocks_stopped_o) : 8'h00;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  illegal_start_a: assert property (
    trig && opcode_illegal_i |=> reset_pin_oe_o && cpu_reset_o) else $error("no illegal reset");
  stop_start_a: assert property (
    trig && opcode_stop_i && !stop_en_q |=> cpu_reset_o) else $error("no stop reset");
  unmapped_start_a: assert property (
    trig && addr_unmapped_i |=> reset_pin_oe_o && cpu_reset_o) else $error("no address reset");
  supply_hold_a: assert property (
    supply_low_i [*7] |-> reset_pin_oe_o && clocks_stopped_o) else $error("supply low not held");
  pin_release_a: assert property (
    $fell(reset_pin_oe_o) |-> pin_cnt_q inside {[31:33]}) else $error("pin release count");
  cpu_release_a: assert property (
    $fell(cpu_reset_o) |-> cpu_cnt_q inside {[63:66]}) else $error("cpu release count");
  pin_first_a: assert property (
    $fell(reset_pin_oe_o) |-> cpu_reset_o ##1 cpu_reset_o) else $error("cpu freed with pin");
  clocks_first_a: assert property (
    $fell(clocks_stopped_o) |-> reset_pin_oe_o && cpu_reset_o) else $error("clocks early");
  pin_with_reset_a: assert property (
    $rose(cpu_reset_o) |-> reset_pin_oe_o) else $error("pin not pulled");
  cover property (trig && opcode_illegal_i);
  cover property (trig && addr_unmapped_i);
  cover property ($fell(clocks_stopped_o));
endmodule

bind reset_source_capture reset_capture_checker #(.WDOG_W(WDOG_W), .STAB_CYCLES(STAB_CYCLES))
  chk (.sys_clk_i, .resetn_i, .osc_en_i, .supply_low_i, .opcode_fetch_i, .opcode_illegal_i,
  .opcode_stop_i, .addr_unmapped_i, .reg_addr_i, .reg_wdata_i, .reg_write_i, .reset_pin_oe_o,
  .clocks_stopped_o, .cpu_reset_o);

/* File: sim/tb_reset_source_capture.sv */
// Self-checking bench for the reset source capture block.
// Assumes the pin partner and the bound checker are compiled with it.
`include "reset_cause_regs.svh"
module tb_reset_source_capture;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, resetn = 1'b0, osc_en = 1'b0, supply_low = 1'b0, fetch = 1'b0;
  logic hold_low = 1'b0, wr_s = 1'b0, rd_s = 1'b0, pin, pin_out, pin_oe, clk_stop, cpu_rst, irq;
  logic [2:0] qual = 3'b000;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00, rdata;
  int err_count = 0, comparisons = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // Clock; oscillator pulse every other cycle so counts differ from clocks
  initial forever #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) osc_en <= ~osc_en;
  reset_source_capture #(.WDOG_W(6), .STAB_CYCLES(16)) dut (.sys_clk_i(sys_clk),
    .resetn_i(resetn), .osc_en_i(osc_en), .supply_low_i(supply_low), .opcode_fetch_i(fetch),
    .opcode_illegal_i(qual[2]), .opcode_stop_i(qual[1]), .addr_unmapped_i(qual[0]),
    .reset_pin_i(pin), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_write_i(wr_s),
    .reg_read_i(rd_s), .reg_rdata_o(rdata), .reset_pin_o(pin_out), .reset_pin_oe_o(pin_oe),
    .clocks_stopped_o(clk_stop), .cpu_reset_o(cpu_rst), .irq_o(irq));
  reset_pin_partner far (.drv_i(pin_out), .oe_i(pin_oe), .hold_low_i(hold_low), .pin_o(pin));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check1(input logic got, input logic exp);
    check8({7'h00, got}, {7'h00, exp});
  endtask
  // Let the edge's updates land before sampling
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge sys_clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge sys_clk);
    rd_s <= 1'b0;
    #1;
    check8(rdata, exp);
  endtask
  // Bounded wait for the CPU hold to reach a level
  task automatic wait_cpu(input logic lvl);
    int n;
    n = 0;
    while (cpu_rst !== lvl && n < 3000) begin
      tick();
      n++;
    end
    if (cpu_rst !== lvl) begin
      err_count++;
      final_report();
    end
  endtask
  // Service the watchdog, then one qualified fetch pulse
  task automatic fire(input logic [2:0] q);
    wr(`WATCHDOG_SERVICE_ADDR, 8'h5a);
    @(posedge sys_clk);
    fetch <= 1'b1;
    qual <= q;
    @(posedge sys_clk);
    fetch <= 1'b0;
    qual <= 3'b000;
  endtask
  task automatic recover();
    wait_cpu(1'b1);
    wait_cpu(1'b0);
    repeat (8) tick();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    wait_cpu(1'b0);
    rd(`RESET_CAUSE_ADDR, `CAUSE_POWER_ON_VALUE);
    wr(`RESET_CAUSE_ADDR, 8'hff);
    rd(`RESET_CAUSE_ADDR, 8'h00);
    rd(16'h0100, 8'h00);
    @(posedge sys_clk);
    qual <= 3'b001;
    repeat (4) @(posedge sys_clk);
    qual <= 3'b000;
    tick();
    check1(cpu_rst, 1'b0);
    fire(3'b100);
    tick();
    check1(pin_oe, 1'b1);
    check1(pin_out, 1'b0);
    recover();
    rd(`RESET_CAUSE_ADDR, 8'h10);
    wr(`IRQ_ENABLE_ADDR, 8'h10);
    tick();
    check1(irq, 1'b1);
    rd(`IRQ_STATUS_ADDR, 8'h10);
    wr(`IRQ_ENABLE_ADDR, 8'h00);
    tick();
    check1(irq, 1'b0);
    wr(`IRQ_ENABLE_ADDR, 8'h10);
    wr(`IRQ_CLEAR_ADDR, 8'h10);
    tick();
    check1(irq, 1'b0);
    rd(`IRQ_STATUS_ADDR, 8'h00);
    fire(3'b010);
    recover();
    rd(`RESET_CAUSE_ADDR, 8'h10);
    wr(`CONFIG_ONE_ADDR, 8'h01);
    fire(3'b010);
    repeat (6) tick();
    check1(cpu_rst, 1'b0);
    fire(3'b001);
    recover();
    rd(`RESET_CAUSE_ADDR, 8'h08);
    @(posedge sys_clk);
    hold_low <= 1'b1;
    fire(3'b100);
    recover();
    fire(3'b001);
    recover();
    @(posedge sys_clk);
    hold_low <= 1'b0;
    rd(`RESET_CAUSE_ADDR, 8'h58);
    repeat (6) begin
      wr(`WATCHDOG_SERVICE_ADDR, 8'h00);
      repeat (20) tick();
    end
    check1(cpu_rst, 1'b0);
    recover();
    rd(`RESET_CAUSE_ADDR, 8'h20);
    @(posedge sys_clk);
    supply_low <= 1'b1;
    repeat (40) tick();
    check1(clk_stop, 1'b1);
    check1(pin_oe, 1'b1);
    @(posedge sys_clk);
    supply_low <= 1'b0;
    wait_cpu(1'b0);
    repeat (8) tick();
    rd(`RESET_CAUSE_ADDR, 8'h02);
    final_report();
  end
endmodule
